// file: design/efs_pkg.sv
// package: constants and types for the ethernet frame statistics block
`default_nettype none
package efs_pkg;
    localparam int RX_GOOD_W = 32;
    localparam int TX_GOOD_W = 32;
    localparam int ERR_W = 20;
    localparam int WORD_W = 32;
    localparam int RX_WORDS = 10;
    localparam int TX_WORDS = 12;
    localparam logic [7:0] RX_LEN_BYTES = 8'h28;
    localparam logic [7:0] TX_LEN_BYTES = 8'h30;
    localparam logic RX_SEL = 1'b0;
    localparam logic TX_SEL = 1'b1;
    localparam logic [13:0] RUNT_LIMIT = 14'h0040;
    localparam logic [13:0] DEF_MAX_FRAME = 14'h05ee;
    // rx snapshot word indices
    localparam logic [3:0] RX_IDX_GOOD = 4'h0;
    localparam logic [3:0] RX_IDX_CRC = 4'h1;
    localparam logic [3:0] RX_IDX_RUNT = 4'h2;
    localparam logic [3:0] RX_IDX_ALIGN = 4'h3;
    localparam logic [3:0] RX_IDX_LONG = 4'h4;
    localparam logic [3:0] RX_IDX_LATE = 4'h5;
    localparam logic [3:0] RX_IDX_BAD = 4'h6;
    localparam logic [3:0] RX_IDX_DROP = 4'h7;
    // tx snapshot word indices
    localparam logic [3:0] TX_IDX_GOOD = 4'h0;
    localparam logic [3:0] TX_IDX_PAUSE = 4'h1;
    localparam logic [3:0] TX_IDX_SINGLE = 4'h2;
    localparam logic [3:0] TX_IDX_MULTI = 4'h3;
    localparam logic [3:0] TX_IDX_EXCOL = 4'h4;
    localparam logic [3:0] TX_IDX_LATE = 4'h5;
    localparam logic [3:0] TX_IDX_UNDER = 4'h6;
    localparam logic [3:0] TX_IDX_DEFER = 4'h7;
    localparam logic [3:0] TX_IDX_CARR = 4'h8;
    localparam logic [3:0] TX_IDX_BAD = 4'h9;
    typedef enum logic [1:0] {EFS_IDLE, EFS_SEND} efs_state_t;
endpackage
`default_nettype wire

// file: design/efs_rx_count.sv
// receive frame counters fed by one status strobe per frame
`default_nettype none
module efs_rx_count (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // frame status
    input wire logic rx_done,
    input wire logic rx_crc_err,
    input wire logic rx_dribble,
    input wire logic rx_too_long,
    input wire logic rx_late_col,
    input wire logic rx_other_err,
    input wire logic rx_fifo_drop,
    input wire logic [13:0] rx_len,
    // counter values
    output logic [efs_pkg::RX_WORDS*efs_pkg::WORD_W-1:0] rx_words
);
    typedef struct packed {
        logic [efs_pkg::RX_GOOD_W-1:0] good;
        logic [efs_pkg::ERR_W-1:0] crc;
        logic [efs_pkg::ERR_W-1:0] runt;
        logic [efs_pkg::ERR_W-1:0] align;
        logic [efs_pkg::ERR_W-1:0] long_f;
        logic [efs_pkg::ERR_W-1:0] late;
        logic [efs_pkg::ERR_W-1:0] bad;
        logic [efs_pkg::ERR_W-1:0] drop;
    } efs_rx_t;
    efs_rx_t r;
    efs_rx_t next_r;
    logic keep;
    logic err;

    // a dropped frame is kept out of every error count
    always_comb begin
        next_r = r;
        keep = rx_done && !rx_fifo_drop;
        err = rx_crc_err || rx_too_long || rx_late_col || rx_other_err;
        if (rx_done && !err) begin
            next_r.good = r.good + 1'b1;
        end
        if (keep && rx_crc_err && !rx_dribble) begin
            next_r.crc = r.crc + 1'b1;
        end
        if (keep && rx_crc_err && rx_len < efs_pkg::RUNT_LIMIT) begin
            next_r.runt = r.runt + 1'b1;
        end
        if (keep && rx_crc_err && rx_dribble) begin
            next_r.align = r.align + 1'b1;
        end
        if (keep && rx_too_long) begin
            next_r.long_f = r.long_f + 1'b1;
        end
        if (keep && rx_late_col) begin
            next_r.late = r.late + 1'b1;
        end
        if (keep && err) begin
            next_r.bad = r.bad + 1'b1;
        end
        if (rx_done && rx_fifo_drop) begin
            next_r.drop = r.drop + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // each counter zero extended into its own 32-bit word, two reserved words
    assign rx_words = {64'h0, 12'h0, r.drop, 12'h0, r.bad, 12'h0, r.late, 12'h0, r.long_f,
                       12'h0, r.align, 12'h0, r.runt, 12'h0, r.crc, r.good};
endmodule
`default_nettype wire

// file: design/efs_tx_count.sv
// transmit frame counters fed by one status strobe per frame
`default_nettype none
module efs_tx_count (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // frame status
    input wire logic tx_done,
    input wire logic tx_pause,
    input wire logic [4:0] tx_col_cnt,
    input wire logic tx_excess_col,
    input wire logic tx_late_col,
    input wire logic tx_underrun,
    input wire logic tx_excess_defer,
    input wire logic tx_carrier_err,
    // counter values
    output logic [efs_pkg::TX_WORDS*efs_pkg::WORD_W-1:0] tx_words
);
    typedef struct packed {
        logic [efs_pkg::TX_GOOD_W-1:0] good;
        logic [efs_pkg::ERR_W-1:0] pause;
        logic [efs_pkg::ERR_W-1:0] single;
        logic [efs_pkg::ERR_W-1:0] multi;
        logic [efs_pkg::ERR_W-1:0] excol;
        logic [efs_pkg::ERR_W-1:0] late;
        logic [efs_pkg::ERR_W-1:0] under;
        logic [efs_pkg::ERR_W-1:0] defer;
        logic [efs_pkg::ERR_W-1:0] carr;
        logic [efs_pkg::ERR_W-1:0] bad;
    } efs_tx_t;
    efs_tx_t r;
    efs_tx_t next_r;
    logic abort;
    logic ok;

    // aborts exclude success; carrier loss is an error but not an abort
    always_comb begin
        next_r = r;
        abort = tx_excess_col || tx_late_col || tx_underrun || tx_excess_defer;
        ok = tx_done && !abort;
        if (ok && !tx_pause && !tx_carrier_err) begin
            next_r.good = r.good + 1'b1;
        end
        if (ok && tx_pause) begin
            next_r.pause = r.pause + 1'b1;
        end
        if (ok && tx_col_cnt == 5'h01) begin
            next_r.single = r.single + 1'b1;
        end
        if (ok && tx_col_cnt > 5'h01) begin
            next_r.multi = r.multi + 1'b1;
        end
        if (tx_done && tx_excess_col) begin
            next_r.excol = r.excol + 1'b1;
        end
        if (tx_done && tx_late_col) begin
            next_r.late = r.late + 1'b1;
        end
        if (tx_done && tx_underrun) begin
            next_r.under = r.under + 1'b1;
        end
        if (tx_done && tx_excess_defer) begin
            next_r.defer = r.defer + 1'b1;
        end
        if (tx_done && tx_carrier_err) begin
            next_r.carr = r.carr + 1'b1;
        end
        if (tx_done && (abort || tx_carrier_err)) begin
            next_r.bad = r.bad + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // two reserved words close the set
    assign tx_words = {64'h0, 12'h0, r.bad, 12'h0, r.carr, 12'h0, r.defer, 12'h0, r.under,
                       12'h0, r.late, 12'h0, r.excol, 12'h0, r.multi, 12'h0, r.single,
                       12'h0, r.pause, r.good};
endmodule
`default_nettype wire

// file: design/efs_top.sv
// top: frame counters with snapshot readout on a statistics request
`default_nettype none
// Behaviour
// - 32-bit good receive count, frames later dropped for fifo room included.
// - receive crc count needs crc error flag with dribble flag clear.
// - 20-bit runt count: under 64 bytes with crc error.
// - 20-bit alignment count: crc error and dribble both set.
// - 20-bit count of frames longer than programmed maximum size.
// - 20-bit count of received frames with late collision.
// - 20-bit total of errored receive frames, fifo drops excluded.
// - 20-bit count of frames dropped for lack of fifo room.
// - a dropped frame with errors counts only as dropped.
// - 32-bit good transmit count, pause frames excluded.
// - 20-bit count of successfully sent pause frames.
// - 20-bit count of frames sent after exactly one collision.
// - 20-bit count of frames sent after two or more collisions.
// - 20-bit count of transmit aborts for excessive collisions.
// - 20-bit count of transmit aborts for late collision.
// - 20-bit count of transmit aborts for buffer underrun.
// - 20-bit count of transmit aborts for excessive deferral.
// - count transmit frames with carrier lost or never present.
// - 20-bit total of transmit frames ending in error.
// - counters are read only through the statistics request.
// - a request captures all counters of the selected set at once; counting continues.
// - counters wrap at maximum and reads never clear them.
// - request index 0 selects receive set, 1 selects transmit set.
// - receive set is 28h bytes, transmit set 30h, one word each.
module efs_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // receive frame status, one-cycle strobe per frame
    input wire logic rx_done,
    input wire logic rx_crc_err,
    input wire logic rx_dribble,
    input wire logic rx_late_col,
    input wire logic rx_other_err,
    input wire logic rx_fifo_drop,
    input wire logic [13:0] rx_len,
    input wire logic [13:0] max_frame_len,
    // transmit frame status, one-cycle strobe per frame
    input wire logic tx_done,
    input wire logic tx_pause,
    input wire logic [4:0] tx_col_cnt,
    input wire logic tx_excess_col,
    input wire logic tx_late_col,
    input wire logic tx_underrun,
    input wire logic tx_excess_defer,
    input wire logic tx_carrier_err,
    // statistics request from the usb control endpoint
    input wire logic stat_req,
    input wire logic stat_sel,
    input wire logic [7:0] stat_len,
    input wire logic stat_ready,
    // statistics data stage
    output logic stat_busy,
    output logic stat_valid,
    output logic [31:0] stat_data,
    output logic stat_last,
    output logic stat_stall
);
    localparam int SNAP_W = efs_pkg::TX_WORDS * efs_pkg::WORD_W;

    typedef struct packed {
        efs_pkg::efs_state_t state;
        logic sel;
        logic [3:0] idx;
        logic [3:0] last_idx;
        logic [SNAP_W-1:0] snap;
        logic busy;
        logic valid;
        logic [31:0] data;
        logic last;
        logic stall;
    } efs_top_t;

    efs_top_t r;
    efs_top_t next_r;
    logic [efs_pkg::RX_WORDS*efs_pkg::WORD_W-1:0] rx_words;
    logic [efs_pkg::TX_WORDS*efs_pkg::WORD_W-1:0] tx_words;
    logic rx_too_long;

    // picks one word of the captured set
    function automatic logic [31:0] efs_word(input logic [SNAP_W-1:0] s, input logic [3:0] i);
        efs_word = s[i*efs_pkg::WORD_W +: efs_pkg::WORD_W];
    endfunction

    // length limit is software programmable, compared per frame
    assign rx_too_long = rx_len > max_frame_len;

    efs_rx_count u_rx (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .rx_done(rx_done),
        .rx_crc_err(rx_crc_err),
        .rx_dribble(rx_dribble),
        .rx_too_long(rx_too_long),
        .rx_late_col(rx_late_col),
        .rx_other_err(rx_other_err),
        .rx_fifo_drop(rx_fifo_drop),
        .rx_len(rx_len),
        .rx_words(rx_words)
    );

    efs_tx_count u_tx (
        .core_clk(core_clk),
        .arst_n(arst_n),
        .tx_done(tx_done),
        .tx_pause(tx_pause),
        .tx_col_cnt(tx_col_cnt),
        .tx_excess_col(tx_excess_col),
        .tx_late_col(tx_late_col),
        .tx_underrun(tx_underrun),
        .tx_excess_defer(tx_excess_defer),
        .tx_carrier_err(tx_carrier_err),
        .tx_words(tx_words)
    );

    // request handling: snapshot costs a wide register but frees the counters
    always_comb begin
        next_r = r;
        next_r.stall = 1'b0;
        case (r.state)
            efs_pkg::EFS_IDLE: begin
                if (stat_req) begin
                    if ((stat_sel == efs_pkg::RX_SEL && stat_len == efs_pkg::RX_LEN_BYTES) ||
                        (stat_sel == efs_pkg::TX_SEL && stat_len == efs_pkg::TX_LEN_BYTES)) begin
                        next_r.sel = stat_sel;
                        // all words captured in the same edge; counters keep running
                        next_r.snap = (stat_sel == efs_pkg::TX_SEL) ? tx_words :
                                      {{(SNAP_W - efs_pkg::RX_WORDS*efs_pkg::WORD_W){1'b0}}, rx_words};
                        next_r.last_idx = (stat_sel == efs_pkg::TX_SEL) ? 4'(efs_pkg::TX_WORDS - 1) :
                                          4'(efs_pkg::RX_WORDS - 1);
                        next_r.idx = 4'h0;
                        next_r.busy = 1'b1;
                        next_r.valid = 1'b1;
                        next_r.data = efs_word(next_r.snap, 4'h0);
                        next_r.last = 1'b0;
                        next_r.state = efs_pkg::EFS_SEND;
                    end else begin
                        next_r.stall = 1'b1; // malformed request refused
                    end
                end
            end
            efs_pkg::EFS_SEND: begin
                if (stat_ready) begin
                    if (r.last) begin
                        next_r.valid = 1'b0;
                        next_r.last = 1'b0;
                        next_r.busy = 1'b0;
                        next_r.state = efs_pkg::EFS_IDLE;
                    end else begin
                        next_r.idx = r.idx + 4'h1;
                        next_r.data = efs_word(r.snap, r.idx + 4'h1);
                        next_r.last = (r.idx + 4'h1) == r.last_idx;
                    end
                end
            end
            default: begin
                next_r.state = efs_pkg::EFS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign stat_busy = r.busy;
    assign stat_valid = r.valid;
    assign stat_data = r.data;
    assign stat_last = r.last;
    assign stat_stall = r.stall;
endmodule
`default_nettype wire

// file: tb/efs_props.sv
// checker: statistics request handshake seen at the top ports
`default_nettype none
module efs_props (
    // clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // request side
    input wire logic stat_req,
    input wire logic stat_sel,
    input wire logic [7:0] stat_len,
    input wire logic stat_ready,
    // data stage
    input wire logic stat_busy,
    input wire logic stat_valid,
    input wire logic [31:0] stat_data,
    input wire logic stat_last,
    input wire logic stat_stall
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    logic [3:0] wcnt;
    logic sel_q;
    logic ok;
    // only the two documented set/length pairs are legal
    assign ok = (stat_sel == efs_pkg::RX_SEL && stat_len == efs_pkg::RX_LEN_BYTES) ||
        (stat_sel == efs_pkg::TX_SEL && stat_len == efs_pkg::TX_LEN_BYTES);
    // words taken since the last request made while not busy, so word index is known
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wcnt <= 4'h0;
            sel_q <= 1'b0;
        end else if (stat_req && !stat_busy) begin
            wcnt <= 4'h0;
            sel_q <= stat_sel;
        end else if (stat_valid && stat_ready) begin
            wcnt <= wcnt + 4'h1;
        end
    end
    sequence take_s;
        stat_req && !stat_busy;
    endsequence
    sequence word_s;
        stat_valid && stat_ready;
    endsequence
    accept_legal_a: assert property (take_s ##0 ok |=> stat_valid && stat_busy && !stat_stall)
        else $error("legal request not answered");
    refuse_bad_a: assert property (take_s ##0 !ok |=> stat_stall && !stat_valid && !stat_busy)
        else $error("bad request not refused");
    stall_pulse_a: assert property (stat_stall |=> !stat_stall)
        else $error("refusal longer than one cycle");
    word_hold_a: assert property (stat_valid && !stat_ready |=> stat_valid && $stable(stat_data))
        else $error("word changed while not taken");
    word_next_a: assert property (word_s ##0 !stat_last |=> stat_valid)
        else $error("data stage ended early");
    stage_end_a: assert property (word_s ##0 stat_last |=> !stat_valid && !stat_busy && !stat_last)
        else $error("data stage did not end");
    word_count_a: assert property (stat_valid && stat_last |-> wcnt == (sel_q ? 4'hb : 4'h9))
        else $error("wrong word count");
    reserved_zero_a: assert property (stat_valid && wcnt >= (sel_q ? 4'ha : 4'h8) |-> stat_data == 32'h0)
        else $error("reserved word not zero");
    busy_ignore_a: assert property (stat_busy && stat_req && !(stat_valid && stat_ready && stat_last)
        |=> stat_busy && !stat_stall)
        else $error("request while busy not ignored");
endmodule
bind efs_top efs_props u_props (.core_clk, .arst_n, .stat_req, .stat_sel, .stat_len, .stat_ready,
    .stat_busy, .stat_valid, .stat_data, .stat_last, .stat_stall);
`default_nettype wire

// file: tb/efs_host_model.sv
// host side model: takes data stage words, promptly or slowly
`default_nettype none
module efs_host_model (
    // clock
    input wire logic core_clk,
    // request seen and pacing choice
    input wire logic stat_req,
    input wire logic slow,
    // data stage
    input wire logic stat_valid,
    input wire logic [31:0] stat_data,
    output logic stat_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] words [12];
    int cnt;
    initial stat_ready = 1'b0;
    // ready moves off the sampling edge; slow pacing stalls every other cycle
    always @(negedge core_clk) stat_ready <= slow ? !stat_ready : 1'b1;
    // words kept in arrival order, index 0 first; capped to avoid overrun
    always @(posedge core_clk) begin
        // a request during a data stage is ignored by the block, so the count must not restart
        if (stat_req && !stat_valid) cnt <= 0;
        else if (stat_valid && stat_ready && cnt < 12) begin
            words[cnt] <= stat_data;
            cnt <= cnt + 1;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// testbench: frame events, statistics readout and comparison
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic core_clk, arst_n, slow;
    logic rx_done, rx_crc_err, rx_dribble, rx_late_col, rx_other_err, rx_fifo_drop;
    logic [13:0] rx_len, max_frame_len;
    logic tx_done, tx_pause, tx_excess_col, tx_late_col, tx_underrun, tx_excess_defer, tx_carrier_err;
    logic [4:0] tx_col_cnt;
    logic stat_req, stat_sel, stat_ready, stat_busy, stat_valid, stat_last, stat_stall;
    logic [7:0] stat_len;
    logic [31:0] stat_data;
    logic [31:0] erx [10];
    logic [31:0] etx [12];
    logic [31:0] snap [10];
    int error_cnt, checks;
    efs_top u_dut (.core_clk, .arst_n, .rx_done, .rx_crc_err, .rx_dribble, .rx_late_col, .rx_other_err,
        .rx_fifo_drop, .rx_len, .max_frame_len, .tx_done, .tx_pause, .tx_col_cnt, .tx_excess_col,
        .tx_late_col, .tx_underrun, .tx_excess_defer, .tx_carrier_err, .stat_req, .stat_sel, .stat_len,
        .stat_ready, .stat_busy, .stat_valid, .stat_data, .stat_last, .stat_stall);
    efs_host_model u_host (.core_clk, .stat_req, .slow, .stat_valid, .stat_data, .stat_ready);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // one receive frame; f is crc, dribble, late, other, fifo drop
    task automatic rxf(input logic [4:0] f, input logic [13:0] len);
        logic lng, err;
        lng = len > max_frame_len;
        err = f[4] || lng || f[2] || f[1];
        @(negedge core_clk);
        {rx_crc_err, rx_dribble, rx_late_col, rx_other_err, rx_fifo_drop} = f;
        rx_len = len;
        rx_done = 1'b1;
        if (!err) erx[0]++;
        if (f[0]) erx[7]++;
        else begin
            if (f[4] && !f[3]) erx[1]++;
            if (f[4] && len < 14'h0040) erx[2]++;
            if (f[4] && f[3]) erx[3]++;
            if (lng) erx[4]++;
            if (f[2]) erx[5]++;
            if (err) erx[6]++;
        end
        @(negedge core_clk);
        rx_done = 1'b0;
    endtask
    // one transmit frame; ab is excess col, late, underrun, deferral, carrier
    task automatic txf(input logic p, input logic [4:0] c, input logic [4:0] ab);
        logic abt;
        abt = |ab[4:1];
        @(negedge core_clk);
        {tx_pause, tx_col_cnt} = {p, c};
        {tx_excess_col, tx_late_col, tx_underrun, tx_excess_defer, tx_carrier_err} = ab;
        tx_done = 1'b1;
        if (!abt && !p && !ab[0]) etx[0]++;
        if (!abt && p) etx[1]++;
        if (!abt && c == 5'h01) etx[2]++;
        if (!abt && c > 5'h01) etx[3]++;
        for (int i = 0; i < 5; i++) if (ab[4-i]) etx[4+i]++;
        if (|ab) etx[9]++;
        @(negedge core_clk);
        tx_done = 1'b0;
    endtask
    task automatic req(input logic s, input logic [7:0] n);
        @(negedge core_clk);
        {stat_sel, stat_len, stat_req} = {s, n, 1'b1};
        @(negedge core_clk);
        stat_req = 1'b0;
    endtask
    // bounded wait for the data stage to finish
    task automatic wait_done;
        for (int k = 0; k < 200 && stat_busy !== 1'b0; k++) @(negedge core_clk);
        chk(stat_busy, 1'b0);
    endtask
    task automatic chk_rx(input logic [31:0] e [10]);
        chk(u_host.cnt, 10);
        for (int i = 0; i < 10; i++) chk(u_host.words[i], e[i]);
    endtask
    task automatic rd_rx;
        req(efs_pkg::RX_SEL, efs_pkg::RX_LEN_BYTES);
        wait_done();
        chk_rx(erx);
    endtask
    task automatic t_rx;
        logic [18:0] t [11] = '{19'h00040, 19'h04040, 19'h4003f, 19'h40040, 19'h60040, 19'h00065,
            19'h00064, 19'h10040, 19'h08040, 19'h4403f, 19'h20040};
        rd_rx();
        for (int i = 0; i < 11; i++) rxf(t[i][18:14], t[i][13:0]);
        rd_rx();
        $display("test rx counters done");
    endtask
    task automatic t_tx;
        logic [10:0] t [12] = '{11'h000, 11'h400, 11'h020, 11'h040, 11'h3e0, 11'h010, 11'h008, 11'h004,
            11'h002, 11'h001, 11'h410, 11'h021};
        for (int i = 0; i < 12; i++) txf(t[i][10], t[i][9:5], t[i][4:0]);
        req(efs_pkg::TX_SEL, efs_pkg::TX_LEN_BYTES);
        wait_done();
        chk(u_host.cnt, 12);
        for (int i = 0; i < 12; i++) chk(u_host.words[i], etx[i]);
        $display("test tx counters done");
    endtask
    // frames arrive during a slow readout: copy stays, counting goes on
    task automatic t_snap;
        slow = 1'b1;
        snap = erx;
        req(efs_pkg::RX_SEL, efs_pkg::RX_LEN_BYTES);
        for (int i = 0; i < 3; i++) rxf(5'h00, 14'h0040);
        wait_done();
        chk_rx(snap);
        slow = 1'b0;
        rd_rx();
        $display("test snapshot done");
    endtask
    task automatic t_refuse;
        logic [8:0] t [3] = '{9'h030, 9'h128, 9'h000};
        for (int i = 0; i < 3; i++) begin
            req(t[i][8], t[i][7:0]);
            chk({stat_stall, stat_valid}, 2'b10);
            @(negedge core_clk);
            chk(stat_stall, 1'b0);
        end
        req(efs_pkg::RX_SEL, efs_pkg::RX_LEN_BYTES);
        req(efs_pkg::TX_SEL, efs_pkg::TX_LEN_BYTES);
        wait_done();
        chk_rx(erx);
        $display("test refusal done");
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // whole run needs about 140 cycles; this is far beyond it
    initial begin
        #1000000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        {rx_done, rx_crc_err, rx_dribble, rx_late_col, rx_other_err, rx_fifo_drop, rx_len} = '0;
        {tx_done, tx_pause, tx_col_cnt, tx_excess_col, tx_late_col, tx_underrun} = '0;
        {tx_excess_defer, tx_carrier_err, stat_req, stat_sel, stat_len, slow} = '0;
        max_frame_len = 14'h0064;
        foreach (etx[i]) etx[i] = 32'h0;
        foreach (erx[i]) erx[i] = 32'h0;
        arst_n = 1'b0;
        repeat (2) @(negedge core_clk);
        arst_n = 1'b1;
        t_rx();
        t_tx();
        t_snap();
        t_refuse();
        report_and_stop();
    end
endmodule
`default_nettype wire
